//--- rtl/tlc_core.sv
// Purpose: current level control with arm, trigger, cancel, wait and protection
// Assumes: pins from the bus interface and power stage are asynchronous
// Notes:   Contract
//          Contract
//          - bus trigger command triggers when source is bus
//          - group execute trigger acts like bus trigger
//          - self test returns zero or fault code
//          - wait holds off commands until pending done
//          - only device clear aborts a wait
//          - cancel drops trigger, pending equals immediate
//          - cancel clears waiting for trigger flag
//          - continuous arm rearms right after cancel
//          - power on, recall, reset imply cancel
//          - trigger moves pending level to output
//          - immediate writes leave pending level untouched
//          - unset pending reads back immediate level
//          - pending applied only when armed
//          - protection plus constant current trips output
//          - only protection clear releases overcurrent latch
//          - query only registers refuse writes
//          - single arm covers one trigger only
//          - unarmed system ignores all triggers
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tlc_core (
    input  wire logic                     pclk,        // bus clock
    input  wire logic                     presetn,     // async reset, low
    input  wire logic                     psel,        // apb select
    input  wire logic                     penable,     // apb enable
    input  wire logic                     pwrite,      // apb direction
    input  wire logic [7:0]               paddr,       // apb byte address
    input  wire logic [31:0]              pwdata,      // apb write data
    output logic      [31:0]              prdata,      // apb read data
    output logic                          pready,      // apb ready
    output logic                          pslverr,     // apb error
    input  wire logic                     bus_get,     // group execute trigger
    input  wire logic                     bus_dcl,     // device clear
    input  wire logic                     ext_trig,    // external trigger
    input  wire logic                     cc_mode,     // constant current state
    input  wire logic [tlc_pkg::FLT_W-1:0] hw_fault,   // self test fault lines
    output logic [tlc_pkg::LVL_W-1:0]     level_out,   // applied current level
    output logic                          output_on,   // output enabled
    output logic                          wtg_out,     // waiting for trigger
    output logic                          irq          // interrupt, high
);
    ////////////////////////////////////////////////////////////////////
    logic [tlc_pkg::SY_W-1:0]  sy1;
    logic [tlc_pkg::SY_W-1:0]  sy2;
    logic [tlc_pkg::SY_W-1:0]  sy3;
    logic                      get_rise;
    logic                      dcl_rise;
    logic                      ext_rise;
    logic                      cc_s;
    logic [tlc_pkg::FLT_W-1:0] flt_s;

    // two flop synchronisers plus edge stage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy1 <= '0;
            sy2 <= '0;
            sy3 <= '0;
        end else begin
            sy1 <= {hw_fault, cc_mode, ext_trig, bus_dcl, bus_get};
            sy2 <= sy1;
            sy3 <= sy2;
        end
    end

    assign get_rise = sy2[tlc_pkg::SY_GET] & ~sy3[tlc_pkg::SY_GET];
    assign dcl_rise = sy2[tlc_pkg::SY_DCL] & ~sy3[tlc_pkg::SY_DCL];
    assign ext_rise = sy2[tlc_pkg::SY_EXT] & ~sy3[tlc_pkg::SY_EXT];
    assign cc_s     = sy2[tlc_pkg::SY_CC];
    assign flt_s    = sy2[tlc_pkg::SY_W-1:4];

    ////////////////////////////////////////////////////////////////////
    logic                      acc;
    logic                      done;
    logic                      wr;
    logic                      cmd_wr;
    logic                      sel_ctrl;
    logic                      sel_cmd;
    logic                      sel_imm;
    logic                      sel_pend;
    logic                      sel_stat;
    logic                      sel_test;
    logic                      sel_ist;
    logic                      sel_ien;
    logic                      sel_iclr;
    logic                      mapped;
    logic                      ro_reg;
    logic                      wo_reg;
    logic                      wait_busy;
    tlc_pkg::tlc_st_type       st_state;

    // address decode
    assign sel_ctrl = paddr == tlc_pkg::OFF_CTRL;
    assign sel_cmd  = paddr == tlc_pkg::OFF_CMD;
    assign sel_imm  = paddr == tlc_pkg::OFF_IMM;
    assign sel_pend = paddr == tlc_pkg::OFF_PEND;
    assign sel_stat = paddr == tlc_pkg::OFF_STAT;
    assign sel_test = paddr == tlc_pkg::OFF_TEST;
    assign sel_ist  = paddr == tlc_pkg::OFF_IRQ_ST;
    assign sel_ien  = paddr == tlc_pkg::OFF_IRQ_EN;
    assign sel_iclr = paddr == tlc_pkg::OFF_IRQ_CLR;
    assign mapped   = sel_ctrl | sel_cmd | sel_imm | sel_pend | sel_stat | sel_test | sel_ist | sel_ien | sel_iclr;
    assign ro_reg   = sel_stat | sel_test | sel_ist;
    assign wo_reg   = sel_cmd | sel_iclr;

    // writes stall
    // ready: writes wait out a pending wait, test reads wait for result
    assign acc     = psel & penable;
    assign pready  = ~(acc & ((pwrite & wait_busy) |
                     (~pwrite & sel_test & (st_state != tlc_pkg::TLC_ST_DONE))));
    assign pslverr = acc & pready & (~mapped | (pwrite & ro_reg) | (~pwrite & wo_reg));
    assign done    = acc & pready;
    assign wr      = done & pwrite & ~pslverr;
    assign cmd_wr  = wr & sel_cmd;

    ////////////////////////////////////////////////////////////////////
    logic                      cont;
    logic                      src_ext;
    logic                      ocp_en;
    logic                      out_req;
    logic                      armed;
    logic                      pend_valid;
    logic [tlc_pkg::LVL_W-1:0] imm;
    logic [tlc_pkg::LVL_W-1:0] pend;
    logic                      c_trg;
    logic                      c_cancel;
    logic                      c_reinit;
    logic                      cancel_any;
    logic                      trig_evt;
    logic                      oc_flag;

    assign c_trg      = cmd_wr & pwdata[tlc_pkg::CMD_TRG];
    assign c_cancel   = cmd_wr & pwdata[tlc_pkg::CMD_CANCEL];
    assign c_reinit   = cmd_wr & (pwdata[tlc_pkg::CMD_RECALL] | pwdata[tlc_pkg::CMD_RESET]);
    assign cancel_any = c_cancel | c_reinit;
    // trigger gating
    // bus sources only count when selected, nothing counts unless armed
    assign trig_evt   = armed & ~cancel_any &
                        ((~src_ext & (c_trg | get_rise)) | (src_ext & ext_rise));

    // control settings; recall and reset clear mode and source, only reset also clears protection and output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cont    <= 1'b0;
            src_ext <= 1'b0;
            ocp_en  <= 1'b0;
            out_req <= 1'b0;
        end else if (c_reinit) begin
            cont    <= 1'b0;
            src_ext <= 1'b0;
            ocp_en  <= ocp_en & ~pwdata[tlc_pkg::CMD_RESET];
            out_req <= out_req & ~pwdata[tlc_pkg::CMD_RESET];
        end else if (wr & sel_ctrl) begin
            cont    <= pwdata[tlc_pkg::CTRL_CONT];
            src_ext <= pwdata[tlc_pkg::CTRL_SRC];
            ocp_en  <= pwdata[tlc_pkg::CTRL_OCP];
            out_req <= pwdata[tlc_pkg::CTRL_OUT];
        end
    end

    // arm state
    // the arm bit is the waiting-for-trigger flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            armed <= 1'b0;
        end else if (cancel_any) begin
            armed <= cont & ~c_reinit;
        end else if (trig_evt & ~cont) begin
            armed <= 1'b0;
        end else if ((cmd_wr & pwdata[tlc_pkg::CMD_ARM]) | cont) begin
            armed <= 1'b1;
        end
    end

    // immediate level
    // only an armed trigger moves the pending level out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imm <= tlc_pkg::IMM_RST;
        end else if (cmd_wr & pwdata[tlc_pkg::CMD_RESET]) begin
            imm <= tlc_pkg::IMM_RST;
        end else if (trig_evt & pend_valid) begin
            imm <= pend;
        end else if (wr & sel_imm) begin
            imm <= pwdata[tlc_pkg::LVL_W-1:0];
        end
    end

    // pending level
    // untouched by immediate writes, dropped by trigger or cancel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend       <= tlc_pkg::IMM_RST;
            pend_valid <= 1'b0;
        end else if (wr & sel_pend) begin
            pend       <= pwdata[tlc_pkg::LVL_W-1:0];
            pend_valid <= 1'b1;
        end else if (cancel_any | trig_evt) begin
            pend_valid <= 1'b0;
        end
    end

    // wait tracking
    // device clear wins; otherwise ends when nothing is pending
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_busy <= 1'b0;
        end else if (dcl_rise) begin
            wait_busy <= 1'b0;
        end else if (cmd_wr & pwdata[tlc_pkg::CMD_WAIT] & armed & pend_valid) begin
            wait_busy <= 1'b1;
        end else if (~(armed & pend_valid)) begin
            wait_busy <= 1'b0;
        end
    end

    // overcurrent latch
    // trip wins over clear while the cause persists
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_flag <= 1'b0;
        end else if (ocp_en & cc_s) begin
            oc_flag <= 1'b1;
        end else if (cmd_wr & pwdata[tlc_pkg::CMD_PCLR]) begin
            oc_flag <= 1'b0;
        end
    end

    // outputs; the output returns to its request once released
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            output_on <= 1'b0;
            level_out <= tlc_pkg::IMM_RST;
        end else begin
            output_on <= out_req & ~oc_flag;
            level_out <= imm;
        end
    end

    assign wtg_out = armed;

    ////////////////////////////////////////////////////////////////////
    logic [3:0]                st_cnt;
    logic [7:0]                st_code;
    logic                      st_evt;

    // self test run on query
    // a test read starts the run and stalls until the code is ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_state <= tlc_pkg::TLC_ST_IDLE;
            st_cnt   <= '0;
            st_code  <= '0;
        end else begin
            case (st_state)
                tlc_pkg::TLC_ST_IDLE: begin
                    if (acc & ~pwrite & sel_test) begin
                        st_state <= tlc_pkg::TLC_ST_RUN;
                        st_cnt   <= 4'(tlc_pkg::ST_CYCLES - 1);
                    end
                end
                tlc_pkg::TLC_ST_RUN: begin
                    if (st_cnt == 4'h0) begin
                        st_state <= tlc_pkg::TLC_ST_LATCH;
                        st_code  <= '0;
                        for (int i = tlc_pkg::FLT_W - 1; i >= 0; i--) begin
                            if (flt_s[i]) begin
                                st_code <= 8'(i + 1);
                            end
                        end
                    end else begin
                        st_cnt <= st_cnt - 4'h1;
                    end
                end
                tlc_pkg::TLC_ST_LATCH: st_state <= tlc_pkg::TLC_ST_DONE;
                tlc_pkg::TLC_ST_DONE: begin
                    if (done) begin
                        st_state <= tlc_pkg::TLC_ST_IDLE;
                    end
                end
                default: st_state <= tlc_pkg::TLC_ST_IDLE;
            endcase
        end
    end

    assign st_evt = st_state == tlc_pkg::TLC_ST_LATCH;

    ////////////////////////////////////////////////////////////////////
    logic [tlc_pkg::IRQ_N-1:0] irq_st;
    logic [tlc_pkg::IRQ_N-1:0] irq_en;
    logic [tlc_pkg::IRQ_N-1:0] irq_ev;
    logic [tlc_pkg::IRQ_N-1:0] irq_clr;

    assign irq_ev  = {st_evt, ocp_en & cc_s & ~oc_flag, trig_evt};
    assign irq_clr = (wr & sel_iclr) ? pwdata[tlc_pkg::IRQ_N-1:0] : '0;

    // sticky status, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st <= '0;
            irq_en <= '0;
        end else begin
            irq_st <= (irq_st & ~irq_clr) | irq_ev;
            if (wr & sel_ien) begin
                irq_en <= pwdata[tlc_pkg::IRQ_N-1:0];
            end
        end
    end

    assign irq = |(irq_st & irq_en);

    ////////////////////////////////////////////////////////////////////
    logic [31:0]               rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (1'b1)
            sel_ctrl: rd_mux = {28'h0, out_req, ocp_en, src_ext, cont};
            sel_imm:  rd_mux = {16'h0, imm};
            sel_pend: rd_mux = {16'h0, pend_valid ? pend : imm};
            sel_stat: rd_mux = {26'h0, st_state != tlc_pkg::TLC_ST_IDLE, output_on,
                                wait_busy, pend_valid, oc_flag, armed};
            sel_test: rd_mux = {24'h0, st_code};
            sel_ist:  rd_mux = {29'h0, irq_st};
            sel_ien:  rd_mux = {29'h0, irq_en};
            default:  rd_mux = 32'h0000_0000;
        endcase
    end

    // read data captured each cycle of a read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~pwrite) begin
            prdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence seq_ocp_trip;
        oc_flag ##1 !output_on;
    endsequence

    bus_trig_a: assert property (c_trg & armed & !src_ext & !cancel_any |=> irq_st[tlc_pkg::IRQ_TRIG])
        else $error("bus trigger did not fire");
    get_trig_a: assert property (get_rise & armed & !src_ext & !cancel_any & pend_valid
                                 |-> ##2 level_out == $past(pend, 2))
        else $error("get trigger did not apply level");
    test_code_a: assert property (st_evt |-> (st_code == 8'h00) == ($past(flt_s) == 4'h0))
        else $error("self test code wrong");
    wait_hold_a: assert property (wait_busy & acc & pwrite |-> !pready)
        else $error("write passed during wait");
    dcl_abort_a: assert property (dcl_rise |=> !wait_busy)
        else $error("device clear did not end wait");
    cancel_pend_a: assert property (cancel_any & !(wr & sel_pend) |=> !pend_valid)
        else $error("cancel kept pending level");
    cancel_wtg_a: assert property (c_cancel & !cont |=> !wtg_out)
        else $error("cancel left waiting flag");
    cont_rearm_a: assert property (c_cancel & !c_reinit & cont |=> wtg_out)
        else $error("continuous arm not restored");
    single_shot_a: assert property (trig_evt & !cont & !cancel_any |=> !armed)
        else $error("single arm survived trigger");
    unarmed_hold_a: assert property (!armed & !(wr & sel_imm) & !c_reinit |=> ##1 $stable(level_out))
        else $error("level moved while unarmed");
    ocp_trip_a: assert property (ocp_en & cc_s |=> seq_ocp_trip)
        else $error("overcurrent did not trip");
    oc_latch_a: assert property (oc_flag & !(cmd_wr & pwdata[tlc_pkg::CMD_PCLR]) |=> oc_flag)
        else $error("overcurrent latch dropped");
endmodule
`default_nettype wire

//--- rtl/tlc_pkg.sv
// Purpose: shared constants for the triggered level control block
// Assumes: APB slave with 32-bit data, one register per aligned word
// Notes:   the command register bits act as one-shot strobes
package tlc_pkg;
    // timing and widths
    localparam int CLK_PERIOD_NS = 20;
    localparam int ST_TIME_NS    = 200;
    localparam int ST_CYCLES     = (ST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LVL_W         = 16;
    localparam int FLT_W         = 4;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_CMD     = 8'h04;
    localparam logic [7:0] OFF_IMM     = 8'h08;
    localparam logic [7:0] OFF_PEND    = 8'h0C;
    localparam logic [7:0] OFF_STAT    = 8'h10;
    localparam logic [7:0] OFF_TEST    = 8'h14;
    localparam logic [7:0] OFF_IRQ_ST  = 8'h18;
    localparam logic [7:0] OFF_IRQ_EN  = 8'h1C;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h20;
    // control register fields
    localparam int CTRL_CONT = 0;
    localparam int CTRL_SRC  = 1;
    localparam int CTRL_OCP  = 2;
    localparam int CTRL_OUT  = 3;
    // command register strobes
    localparam int CMD_ARM    = 0;
    localparam int CMD_TRG    = 1;
    localparam int CMD_CANCEL = 2;
    localparam int CMD_WAIT   = 3;
    localparam int CMD_PCLR   = 4;
    localparam int CMD_RECALL = 5;
    localparam int CMD_RESET  = 6;
    // interrupt events
    localparam int IRQ_N    = 3;
    localparam int IRQ_TRIG = 0;
    localparam int IRQ_OC   = 1;
    localparam int IRQ_TEST = 2;
    // reset values
    localparam logic [LVL_W-1:0] IMM_RST = 16'h0000;
    // input synchroniser bit positions
    localparam int SY_GET = 0;
    localparam int SY_DCL = 1;
    localparam int SY_EXT = 2;
    localparam int SY_CC  = 3;
    localparam int SY_W   = 4 + FLT_W;
    typedef enum logic [1:0] {TLC_ST_IDLE, TLC_ST_RUN, TLC_ST_LATCH, TLC_ST_DONE} tlc_st_type;
endpackage

//--- testbench/tlc_remote_model.sv
// Purpose: remote controller side, turns one-cycle requests into bus line pulses
// Assumes: requests come from the bench as one-cycle strobes on pclk
// Notes:   each pulse lasts four cycles so the block's synchroniser sees it
`timescale 1ns/10ps
`default_nettype none
module tlc_remote_model (
    input  wire logic       pclk,     // bus clock
    input  wire logic       presetn,  // async reset, low
    input  wire logic [2:0] req,      // 0 execute trigger, 1 device clear, 2 ext
    output logic            bus_get,  // group execute trigger line
    output logic            bus_dcl,  // device clear line
    output logic            ext_trig  // external trigger line
);
    logic [2:0] cnt [3];
    ////////////////////////////////////////////////////////////////////////////
    // controller sends pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 3; i++) begin
                cnt[i] <= 3'h0;
            end
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (req[i]) begin
                    cnt[i] <= 3'h4;
                end else if (cnt[i] != 3'h0) begin
                    cnt[i] <= cnt[i] - 3'h1;
                end
            end
        end
    end
    // lines idle low between pulses
    assign bus_get  = (cnt[0] != 3'h0);
    assign bus_dcl  = (cnt[1] != 3'h0);
    assign ext_trig = (cnt[2] != 3'h0);
endmodule
`default_nettype wire

//--- testbench/test_triggered_level_control.sv
// Purpose: self-checking bench for the triggered level control block
// Assumes: apb master with one idle cycle between transfers
// Notes:   async pins are given eight cycles to act
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin mismatches++; $display("ERROR %s exp %h got %h", nm, ex, gt); end end
module test_triggered_level_control;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [2:0]  req = 3'h0;
    logic        cc_mode = 1'b0;
    logic [3:0]  hw_fault = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        bus_get;
    logic        bus_dcl;
    logic        ext_trig;
    logic [15:0] level_out;
    logic        output_on;
    logic        wtg_out;
    logic        irq;
    logic [31:0] rv;
    logic        ev;
    int          nw;
    int          mismatches = 0;
    int          total_checks = 0;
    ////////////////////////////////////////////////////////////////////////////
    // clock and instances
    always #10 pclk = ~pclk;
    tlc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .bus_get(bus_get), .bus_dcl(bus_dcl), .ext_trig(ext_trig), .cc_mode(cc_mode),
        .hw_fault(hw_fault), .level_out(level_out), .output_on(output_on), .wtg_out(wtg_out), .irq(irq));
    tlc_remote_model ctl (.pclk(pclk), .presetn(presetn), .req(req), .bus_get(bus_get),
        .bus_dcl(bus_dcl), .ext_trig(ext_trig));
    ////////////////////////////////////////////////////////////////////////////
    // apb transfer; pready, read data and error are taken at the same rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 400);
        if (n >= 400) begin
            mismatches++;
            end_of_test();
        end
        nw = n;
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic cmd(input int b);
        wr(tlc_pkg::OFF_CMD, 32'h1 << b);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // one-cycle request to the controller model
    task automatic pulse(input int i);
        @(posedge pclk);
        req[i] <= 1'b1;
        @(posedge pclk);
        req[i] <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // watchdog against a hung handshake
    initial begin
        tick(20000);
        mismatches++;
        end_of_test();
    end
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        tick(5);
        presetn <= 1'b1;
        tick(1);
        `CHK("level rst", 16'h0000, level_out)
        `CHK("wtg rst", 1'b0, wtg_out)
        rd(8'h40);
        `CHK("unmapped", 1'b1, ev)
        rd(tlc_pkg::OFF_CMD);
        `CHK("cmd read", 1'b1, ev)
        wr(tlc_pkg::OFF_STAT, 32'hFFFFFFFF);
        `CHK("stat write", 1'b1, ev)
        $display("test map done");
        wr(tlc_pkg::OFF_IMM, 32'h0123);
        `CHK("no wait", 1, nw)
        rd(tlc_pkg::OFF_PEND);
        `CHK("pend none", 32'h0123, rv)
        wr(tlc_pkg::OFF_PEND, 32'h0456);
        cmd(tlc_pkg::CMD_TRG);
        tick(2);
        `CHK("unarmed", 16'h0123, level_out)
        cmd(tlc_pkg::CMD_ARM);
        tick(1);
        `CHK("wtg arm", 1'b1, wtg_out)
        wr(tlc_pkg::OFF_IMM, 32'h0789);
        rd(tlc_pkg::OFF_PEND);
        `CHK("pend kept", 32'h0456, rv)
        cmd(tlc_pkg::CMD_TRG);
        tick(2);
        `CHK("trig level", 16'h0456, level_out)
        `CHK("wtg trig", 1'b0, wtg_out)
        wr(tlc_pkg::OFF_PEND, 32'h0111);
        cmd(tlc_pkg::CMD_TRG);
        tick(2);
        `CHK("single arm", 16'h0456, level_out)
        wr(tlc_pkg::OFF_CTRL, 32'h1 << tlc_pkg::CTRL_SRC);
        cmd(tlc_pkg::CMD_ARM);
        cmd(tlc_pkg::CMD_TRG);
        tick(2);
        `CHK("src ext cmd", 16'h0456, level_out)
        pulse(2);
        tick(8);
        `CHK("ext trig", 16'h0111, level_out)
        wr(tlc_pkg::OFF_CTRL, 32'h0);
        cmd(tlc_pkg::CMD_ARM);
        wr(tlc_pkg::OFF_PEND, 32'h0222);
        pulse(0);
        tick(8);
        `CHK("get trig", 16'h0222, level_out)
        $display("test trigger done");
        cmd(tlc_pkg::CMD_ARM);
        wr(tlc_pkg::OFF_PEND, 32'h0333);
        cmd(tlc_pkg::CMD_CANCEL);
        tick(1);
        `CHK("wtg cancel", 1'b0, wtg_out)
        rd(tlc_pkg::OFF_PEND);
        `CHK("pend cancel", 32'h0222, rv)
        wr(tlc_pkg::OFF_CTRL, 32'h1 << tlc_pkg::CTRL_CONT);
        cmd(tlc_pkg::CMD_CANCEL);
        tick(2);
        `CHK("cont rearm", 1'b1, wtg_out)
        cmd(tlc_pkg::CMD_RECALL);
        tick(2);
        `CHK("recall wtg", 1'b0, wtg_out)
        rd(tlc_pkg::OFF_CTRL);
        `CHK("recall ctrl", 32'h0, rv)
        wr(tlc_pkg::OFF_IMM, 32'h0555);
        cmd(tlc_pkg::CMD_RESET);
        rd(tlc_pkg::OFF_IMM);
        `CHK("reset imm", 32'h0, rv)
        $display("test cancel done");
        cmd(tlc_pkg::CMD_ARM);
        wr(tlc_pkg::OFF_PEND, 32'h0666);
        cmd(tlc_pkg::CMD_WAIT);
        rd(tlc_pkg::OFF_STAT);
        `CHK("wait busy", 1'b1, rv[3])
        fork
            wr(tlc_pkg::OFF_IMM, 32'h0777);
            begin
                tick(6);
                pulse(0);
            end
        join
        `CHK("held stall", 1'b1, nw > 1)
        rd(tlc_pkg::OFF_IMM);
        `CHK("held write", 32'h0777, rv)
        cmd(tlc_pkg::CMD_ARM);
        wr(tlc_pkg::OFF_PEND, 32'h0888);
        cmd(tlc_pkg::CMD_WAIT);
        pulse(1);
        tick(8);
        rd(tlc_pkg::OFF_STAT);
        `CHK("dcl abort", 1'b0, rv[3])
        `CHK("dcl keeps arm", 1'b1, rv[0])
        cmd(tlc_pkg::CMD_CANCEL);
        $display("test wait done");
        wr(tlc_pkg::OFF_IRQ_EN, 32'h1 << tlc_pkg::IRQ_TEST);
        rd(tlc_pkg::OFF_TEST);
        `CHK("test pass", 32'h0, rv)
        `CHK("test wait", 1 + tlc_pkg::ST_CYCLES + 2, nw)
        tick(2);
        `CHK("irq set", 1'b1, irq)
        wr(tlc_pkg::OFF_IRQ_CLR, 32'h1 << tlc_pkg::IRQ_TEST);
        tick(2);
        `CHK("irq clr", 1'b0, irq)
        hw_fault <= 4'h6;
        wr(tlc_pkg::OFF_IRQ_EN, 32'h0);
        rd(tlc_pkg::OFF_TEST);
        `CHK("test fault", 32'h2, rv)
        rd(tlc_pkg::OFF_IRQ_ST);
        `CHK("irq status", 1'b1, rv[2])
        `CHK("irq masked", 1'b0, irq)
        $display("test selftest done");
        wr(tlc_pkg::OFF_CTRL, 32'h0000000C);
        tick(2);
        `CHK("out on", 1'b1, output_on)
        cc_mode <= 1'b1;
        tick(8);
        `CHK("ocp trip", 1'b0, output_on)
        cmd(tlc_pkg::CMD_PCLR);
        rd(tlc_pkg::OFF_STAT);
        `CHK("oc stays", 1'b1, rv[1])
        cc_mode <= 1'b0;
        tick(6);
        cmd(tlc_pkg::CMD_PCLR);
        rd(tlc_pkg::OFF_STAT);
        `CHK("oc clear", 1'b0, rv[1])
        `CHK("out back", 1'b1, output_on)
        $display("test protect done");
        end_of_test();
    end
endmodule
`default_nettype wire
